/* include/bwb_pkg.sv */
// bwb_pkg: constants shared by the 8/16-bit bus bridge control block.
// assumes a 25 MHz system clock and an AXI4-Lite register port with 32-bit data.
package bwb_pkg;

  localparam int          SEQ_WIDTH        = 3;
  localparam int          AXI_ADDR_WIDTH   = 4;
  localparam int          SYNC_WIDTH       = 10;

  localparam logic [3:0]  CTRL_OFFSET      = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET    = 4'h4;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;
  localparam int          CTRL_ENABLE_BIT  = 0;

  localparam int          STAT_SEQ_LSB     = 0;
  localparam int          STAT_LA0_BIT     = 3;
  localparam int          STAT_WAIT_BIT    = 4;
  localparam int          STAT_DMA_BIT     = 5;
  localparam int          STAT_BYTE_BIT    = 6;

  // sequencer counts, one per clock period of a controller cycle
  localparam logic [2:0]  SEQ_FIRST        = 3'h0;
  localparam logic [2:0]  SEQ_SECOND       = 3'h1;
  localparam logic [2:0]  SEQ_WAIT_UPPER   = 3'h2;
  localparam logic [2:0]  SEQ_WAIT_CAPTURE = 3'h3;
  localparam logic [2:0]  SEQ_EVEN_ADDR    = 3'h4;
  localparam logic [2:0]  SEQ_BOTH_BYTES   = 3'h5;
  localparam logic [2:0]  SEQ_RELEASE      = 3'h6;
  localparam logic [2:0]  SEQ_RESET        = 3'h0;

  localparam logic        OE_RESET         = 1'b1;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // bit positions inside the synchronised pin vector
  localparam int          SYN_CK           = 0;
  localparam int          SYN_A0           = 1;
  localparam int          SYN_SEL          = 2;
  localparam int          SYN_ALE          = 3;
  localparam int          SYN_DMA          = 4;
  localparam int          SYN_BYTE         = 5;
  localparam int          SYN_READ         = 6;
  localparam int          SYN_DS           = 7;
  localparam int          SYN_RD           = 8;
  localparam int          SYN_WR           = 9;

endpackage : bwb_pkg

/* verilog/bwb_seq_counter.sv */
// bwb_seq_counter: 3-bit cycle sequencer, cleared by address latch enable.
// assumes clear is already synchronised to clock.
`timescale 1ns/1ps
`default_nettype none

module bwb_seq_counter
  import bwb_pkg::*;
#(
  parameter int WIDTH = SEQ_WIDTH
) (
  input  wire logic             clock,  // system clock
  input  wire logic             nrst,   // synchronous reset, active low
  input  wire logic             ce,     // clock enable
  input  wire logic             clear,  // restart the cycle count
  output logic      [WIDTH-1:0] count   // current sequencer state
);

  logic [WIDTH-1:0] next_count;

  always_comb begin
    if (clear) begin
      next_count = '0;
    end else begin
      next_count = count + WIDTH'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      count <= '0;
    end else if (ce) begin
      count <= next_count;
    end
  end

endmodule : bwb_seq_counter

`default_nettype wire

/* verilog/bwb_bridge.sv */
// bwb_bridge: control block steering an 8-bit processor bus and a 16-bit dma controller.
// assumes all pin inputs are asynchronous; the AXI4-Lite port shares the system clock.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - split word reads only; dma writes stay byte-wide
// - bridge drives address bit 0 for system
// - processor mode: bit 0 follows while latching
// - outgoing: latch upper, then pass lower and drive together
// - incoming: capture one byte, then present both
// - address latch enable clears the sequencer
// - state 1: read strobe, wait unconditionally
// - state 1: byte pass only byte read, low half
// - reset clears registered outputs; strobe drive enables reset high
// - master strobes driven only while dma owns bus
// - state 2 word read: upper latch clock
// - word read: negate, bit0 low, reassert, release
module bwb_bridge
  import bwb_pkg::*;
(
  input  wire logic                      clock,              // 25 MHz system clock
  input  wire logic                      nrst,               // synchronous reset, active low
  input  wire logic                      ce,                 // clock enable, freezes all state
  input  wire logic [AXI_ADDR_WIDTH-1:0] s_axi_awaddr,       // write address
  input  wire logic                      s_axi_awvalid,      // write address valid
  output logic                           s_axi_awready,      // write address ready
  input  wire logic [31:0]               s_axi_wdata,        // write data
  input  wire logic [3:0]                s_axi_wstrb,        // write byte enables
  input  wire logic                      s_axi_wvalid,       // write data valid
  output logic                           s_axi_wready,       // write data ready
  output logic      [1:0]                s_axi_bresp,        // write response
  output logic                           s_axi_bvalid,       // write response valid
  input  wire logic                      s_axi_bready,       // write response ready
  input  wire logic [AXI_ADDR_WIDTH-1:0] s_axi_araddr,       // read address
  input  wire logic                      s_axi_arvalid,      // read address valid
  output logic                           s_axi_arready,      // read address ready
  output logic      [31:0]               s_axi_rdata,        // read data
  output logic      [1:0]                s_axi_rresp,        // read response
  output logic                           s_axi_rvalid,       // read data valid
  input  wire logic                      s_axi_rready,       // read data ready
  input  wire logic                      halfPeriodClock,    // controller clock, low half qualifies
  input  wire logic                      incomingAddrBit0,   // address bit 0 from the bus
  input  wire logic                      bridgeSel,          // processor selects the bridge
  input  wire logic                      ale,                // address latch enable
  input  wire logic                      dmaOwnsBus,         // hold acknowledge
  input  wire logic                      byteCycleFlag,      // high for a byte cycle
  input  wire logic                      dmaRead,            // controller direction, high = read
  input  wire logic                      dataStrobeIn,       // data strobe pin, input side
  output logic                           dataStrobeOut,      // data strobe pin, output side
  output logic                           dataStrobeOeN,      // data strobe drive, low = driven
  input  wire logic                      readStrobeIn,       // read strobe pin, input side
  output logic                           readStrobeOut,      // read strobe pin, output side
  output logic                           readStrobeOeN,      // read strobe drive, low = driven
  input  wire logic                      writeStrobeIn,      // write strobe pin, input side
  output logic                           writeStrobeOut,     // write strobe pin, output side
  output logic                           writeStrobeOeN,     // write strobe drive, low = driven
  output logic                           latchedAddrBit0,    // system address bit 0
  output logic                           waitReq,            // wait to the controller
  output logic                           toDmaPassEn,        // byte pass toward the controller
  output logic                           latchClkEn,         // clock the dual latch
  output logic                           toBusPassEn,        // lower byte toward the 8-bit bus
  output logic                           latchDriveEn        // drive the latched byte
);

  // --- pin synchronisers ---------------------------------------------------
  logic [SYNC_WIDTH-1:0] rawIn, syncA, syncB, next_syncA, next_syncB;

  assign rawIn = {writeStrobeIn, readStrobeIn, dataStrobeIn, dmaRead, byteCycleFlag,
                  dmaOwnsBus, ale, bridgeSel, incomingAddrBit0, halfPeriodClock};

  always_comb begin
    next_syncA = rawIn;
    next_syncB = syncA;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      syncA <= '0;
      syncB <= '0;
    end else if (ce) begin
      syncA <= next_syncA;
      syncB <= next_syncB;
    end
  end

  logic ckS, a0S, selS, aleS, dmaS, byteS, readS, dsS, rdS, wrS;
  assign {wrS, rdS, dsS, readS, byteS, dmaS, aleS, selS, a0S, ckS} = syncB;

  // --- sequencer -----------------------------------------------------------
  logic [SEQ_WIDTH-1:0] seqState;

  bwb_seq_counter #(.WIDTH(SEQ_WIDTH)) u_seq (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .clear (aleS),
    .count (seqState)
  );

  // --- register file -------------------------------------------------------
  logic        bridgeEn, awHeld, wHeld, next_bridgeEn, next_awHeld, next_wHeld, next_bvalid, next_rvalid;
  logic [3:0]  awAddr, wStrb, next_awAddr, next_wStrb;
  logic [31:0] wData, next_wData, next_rdata;
  logic [1:0]  next_bresp, next_rresp;

  function automatic logic isMapped(input logic [3:0] addr);
    isMapped = (addr == CTRL_OFFSET) || (addr == STATUS_OFFSET);
  endfunction : isMapped

  assign s_axi_awready = ce & ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready  = ce & ~wHeld & ~s_axi_bvalid;
  assign s_axi_arready = ce & ~s_axi_rvalid;

  always_comb begin
    {next_bridgeEn, next_awHeld, next_wHeld} = {bridgeEn, awHeld, wHeld};
    {next_awAddr, next_wData, next_wStrb}    = {awAddr, wData, wStrb};
    {next_bvalid, next_bresp}                = {s_axi_bvalid, s_axi_bresp};
    {next_rvalid, next_rdata, next_rresp}    = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    // write commits once both halves are in; status writes are ignored
    if (awHeld && wHeld && !s_axi_bvalid) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (awAddr == CTRL_OFFSET && wStrb[0]) begin
        next_bridgeEn = wData[CTRL_ENABLE_BIT];
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_rdata  = '0;
      if (s_axi_araddr == CTRL_OFFSET) begin
        next_rdata[CTRL_ENABLE_BIT] = bridgeEn;
      end else if (s_axi_araddr == STATUS_OFFSET) begin
        next_rdata[STAT_SEQ_LSB +: SEQ_WIDTH] = seqState;
        next_rdata[STAT_LA0_BIT]  = latchedAddrBit0;
        next_rdata[STAT_WAIT_BIT] = waitReq;
        next_rdata[STAT_DMA_BIT]  = dmaS;
        next_rdata[STAT_BYTE_BIT] = byteS;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      {bridgeEn, awHeld, wHeld}                <= {CTRL_RESET[CTRL_ENABLE_BIT], 2'b00};
      {awAddr, wData, wStrb}                   <= '0;
      {s_axi_bvalid, s_axi_bresp}              <= {1'b0, RESP_OKAY};
      {s_axi_rvalid, s_axi_rdata, s_axi_rresp} <= {1'b0, 32'h0000_0000, RESP_OKAY};
    end else if (ce) begin
      {bridgeEn, awHeld, wHeld}                <= {next_bridgeEn, next_awHeld, next_wHeld};
      {awAddr, wData, wStrb}                   <= {next_awAddr, next_wData, next_wStrb};
      {s_axi_bvalid, s_axi_bresp}              <= {next_bvalid, next_bresp};
      {s_axi_rvalid, s_axi_rdata, s_axi_rresp} <= {next_rvalid, next_rdata, next_rresp};
    end
  end

  // --- bridge control ------------------------------------------------------
  logic next_la0, next_wait, next_toDma, next_latchClk, next_toBus, next_latchDrive;
  logic next_rdOut, next_wrOut, next_dsOut, next_rdOeN, next_wrOeN, next_dsOeN;
  logic holdA0, dmaMode, cpuMode, wordCycle, dmaWrite;

  always_comb begin
    holdA0          = aleS ? a0S : latchedAddrBit0;
    dmaMode         = bridgeEn & dmaS;
    cpuMode         = bridgeEn & ~dmaS;
    wordCycle       = ~byteS;
    dmaWrite        = ~readS;
    next_la0        = latchedAddrBit0;
    {next_wait, next_toDma, next_latchClk, next_toBus, next_latchDrive} = '0;
    {next_rdOut, next_wrOut, next_dsOut} = '0;
    next_rdOeN      = ~dmaMode;
    next_wrOeN      = ~dmaMode;
    next_dsOeN      = ~cpuMode;
    if (dmaMode) begin
      // odd byte first on a word cycle; bit 0 is the system's only bit 0
      if (!seqState[2]) begin
        if (seqState[1] && !seqState[0]) begin
          next_la0 = (~ckS & wordCycle) | (byteS & holdA0);
        end else begin
          next_la0 = wordCycle | (byteS & holdA0);
        end
      end else begin
        next_la0 = byteS ? holdA0 : 1'b0;
      end
      // words are only ever command fetches, so dma writes stay byte-wide
      if (seqState != SEQ_FIRST) begin
        next_rdOut = readS & dsS;
        next_wrOut = byteS & dmaWrite & dsS;
        next_toBus = byteS & dmaWrite & (seqState < SEQ_EVEN_ADDR);
      end
      case (seqState)
        SEQ_SECOND: begin
          next_wait  = 1'b1;
          next_toDma = byteS & readS & ~ckS;
        end
        SEQ_WAIT_UPPER: begin
          next_wait     = wordCycle;
          next_latchClk = wordCycle & readS;
          next_toDma    = byteS & readS;
        end
        SEQ_WAIT_CAPTURE: begin
          next_wait = wordCycle;
        end
        SEQ_EVEN_ADDR: begin
          next_wait  = wordCycle;
          next_rdOut = byteS & readS & dsS;
        end
        SEQ_BOTH_BYTES: begin
          next_wait       = wordCycle;
          next_toDma      = wordCycle & readS & ~ckS;
          next_latchDrive = wordCycle & readS;
        end
        SEQ_RELEASE: begin
          next_toDma      = wordCycle & readS;
          next_latchDrive = wordCycle & readS;
        end
        default: begin
          next_wait = 1'b0;
        end
      endcase
    end else if (cpuMode) begin
      if (selS) begin
        next_la0 = holdA0;
      end
      // odd write is held in the latch until the even write arrives
      next_latchClk   = selS & ((latchedAddrBit0 & wrS) | (~latchedAddrBit0 & rdS));
      next_toDma      = selS & ~latchedAddrBit0 & wrS;
      next_latchDrive = selS & ((~latchedAddrBit0 & wrS) | (latchedAddrBit0 & rdS));
      next_toBus      = selS & ~latchedAddrBit0 & rdS;
      next_dsOut      = selS & ~latchedAddrBit0 & (wrS | rdS);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      {latchedAddrBit0, waitReq, toDmaPassEn}        <= 3'b000;
      {latchClkEn, toBusPassEn, latchDriveEn}        <= 3'b000;
      {readStrobeOut, writeStrobeOut, dataStrobeOut} <= 3'b000;
      {readStrobeOeN, writeStrobeOeN, dataStrobeOeN} <= {3{OE_RESET}};
    end else if (ce) begin
      {latchedAddrBit0, waitReq, toDmaPassEn}        <= {next_la0, next_wait, next_toDma};
      {latchClkEn, toBusPassEn, latchDriveEn}        <= {next_latchClk, next_toBus, next_latchDrive};
      {readStrobeOut, writeStrobeOut, dataStrobeOut} <= {next_rdOut, next_wrOut, next_dsOut};
      {readStrobeOeN, writeStrobeOeN, dataStrobeOeN} <= {next_rdOeN, next_wrOeN, next_dsOeN};
    end
  end

  // --- checks --------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_ale_clear;
    ce && aleS |=> seqState == SEQ_RESET;
  endproperty
  a_ale_clear: assert property (p_ale_clear)
    else $error("sequencer not cleared by address latch enable");

  property p_advance;
    ce && !aleS |=> seqState == 3'($past(seqState) + 3'h1);
  endproperty
  a_advance: assert property (p_advance)
    else $error("sequencer did not advance by one");

  property p_wait_second;
    ce && dmaMode && seqState == SEQ_SECOND |=> waitReq;
  endproperty
  a_wait_second: assert property (p_wait_second)
    else $error("wait missing in second clock period");

  property p_pass_byte_only;
    ce && dmaMode && seqState == SEQ_SECOND && (wordCycle || ckS) |=> !toDmaPassEn;
  endproperty
  a_pass_byte_only: assert property (p_pass_byte_only)
    else $error("byte pass enabled outside byte read low half");

  property p_undriven;
    ce && !dmaMode |=> readStrobeOeN && writeStrobeOeN;
  endproperty
  a_undriven: assert property (p_undriven)
    else $error("master strobes driven without bus ownership");

  property p_cpu_follow;
    ce && cpuMode && selS && aleS |=> latchedAddrBit0 == $past(a0S);
  endproperty
  a_cpu_follow: assert property (p_cpu_follow)
    else $error("latched bit 0 did not follow incoming bit 0");

  property p_cpu_write_odd;
    ce && cpuMode && selS && wrS && latchedAddrBit0 |=> latchClkEn && !toDmaPassEn && !dataStrobeOut;
  endproperty
  a_cpu_write_odd: assert property (p_cpu_write_odd)
    else $error("odd processor write did not clock the latch alone");

  property p_cpu_read_even;
    ce && cpuMode && selS && rdS && !latchedAddrBit0 |=> toBusPassEn && dataStrobeOut && !latchDriveEn;
  endproperty
  a_cpu_read_even: assert property (p_cpu_read_even)
    else $error("even processor read did not open the lower path");

  property p_upper_capture;
    ce && dmaMode && wordCycle && readS && seqState == SEQ_WAIT_UPPER |=> latchClkEn && waitReq;
  endproperty
  a_upper_capture: assert property (p_upper_capture)
    else $error("upper byte not captured in first wait period");

  property p_even_low;
    ce && dmaMode && wordCycle && seqState[2] |=> !latchedAddrBit0;
  endproperty
  a_even_low: assert property (p_even_low)
    else $error("latched bit 0 not forced low late in word cycle");

endmodule : bwb_bridge

`default_nettype wire

/* verification/bwb_dma_model.sv */
// bwb_dma_model: far side, a 16-bit dma controller running one bus cycle per go pulse.
// assumes the bench raises go for one clock while the model is idle.
`timescale 1ns/1ps
`default_nettype none

module bwb_dma_model (
  input  wire logic clock,    // system clock
  input  wire logic go,       // start one bus cycle
  input  wire logic word,     // word cycle when high
  input  wire logic rd,       // read cycle when high
  output logic      ale,      // address latch enable
  output logic      ck,       // controller clock
  output logic      ds,       // data strobe
  output logic      dmaRead,  // direction, high = read
  output logic      byteFlag, // high for a byte cycle
  output logic      busy      // cycle in progress
);
  int n;
  initial begin
    n = 0; ale = 0; ck = 0; ds = 0; dmaRead = 0; byteFlag = 1; busy = 0;
  end
  always @(posedge clock) begin
    ck <= ~ck;
    if (go && !busy) begin
      busy     <= 1'b1;
      n        <= 0;
      ale      <= 1'b1;
      dmaRead  <= rd | word;
      byteFlag <= !word;
    end else if (busy) begin
      n   <= n + 1;
      // ale held three edges so the two-flop sync sees it
      ale <= (n < 2);
      ds  <= (n >= 1 && n < 14);
      if (n == 16) busy <= 1'b0;
    end
  end
endmodule : bwb_dma_model
`default_nettype wire

/* verification/test_bwb_bridge.sv */
// test_bwb_bridge: self-checking bench for the bridge control block.
// assumes 25 MHz clock; dma side from bwb_dma_model, processor side from the bench.
`timescale 1ns/1ps
`default_nettype none

module test_bwb_bridge;
  import bwb_pkg::*;
  logic clock = 0, nrst = 0, own = 0, sel = 0, pAle = 0, a0 = 0, pRd = 0, pWr = 0, go = 0, wd = 0, rdq = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd32;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp, resp;
  logic dsO, dsN, rsO, rsN, wsO, wsN, la0, waitReq, toDma, lClk, toBus, lDrv;
  logic mAle, ck, mDs, mRead, mByte, mBusy;
  logic [7:0] seen = 0;
  logic [2:0] busyLag = 0; // output lag: two sync flops and the output register
  int bad_count = 0, samples_checked = 0, cyc = 0;
  wire aleW = own ? mAle : pAle;
  always #20 clock = ~clock;
  bwb_dma_model dma_u (.clock(clock), .go(go), .word(wd), .rd(rdq), .ale(mAle), .ck(ck), .ds(mDs),
    .dmaRead(mRead), .byteFlag(mByte), .busy(mBusy));
  bwb_bridge dut_u (.clock(clock), .nrst(nrst), .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .halfPeriodClock(ck), .incomingAddrBit0(a0),
    .bridgeSel(sel), .ale(aleW), .dmaOwnsBus(own), .byteCycleFlag(mByte), .dmaRead(mRead),
    .dataStrobeIn(dsN ? mDs : dsO), .dataStrobeOut(dsO), .dataStrobeOeN(dsN),
    .readStrobeIn(rsN ? pRd : rsO), .readStrobeOut(rsO), .readStrobeOeN(rsN),
    .writeStrobeIn(wsN ? pWr : wsO), .writeStrobeOut(wsO), .writeStrobeOeN(wsN),
    .latchedAddrBit0(la0), .waitReq(waitReq), .toDmaPassEn(toDma), .latchClkEn(lClk),
    .toBusPassEn(toBus), .latchDriveEn(lDrv));
  // sticky record of eight controls seen during one dma cycle
  always @(posedge clock) begin
    cyc <= cyc + 1;
    busyLag <= {busyLag[1:0], mBusy};
    if (go) seen <= '0;
    else if (busyLag[2]) seen <= seen | {waitReq, lClk, lDrv, toDma, rsO, wsO, toBus, !rsN};
    if (cyc == 5000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w, b;
    aw = 1; w = 1; b = 0;
    @(posedge clock);
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
    while (!b) begin
      @(negedge clock);
      b = bv; resp = bresp; aw = aw & !awr; w = w & !wr;
      @(posedge clock);
      awv <= aw; wv <= w;
    end
    bready <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    logic ar, r;
    ar = 1; r = 0;
    @(posedge clock);
    araddr <= a; arv <= 1; rready <= 1;
    while (!r) begin
      @(negedge clock);
      r = rv; rd32 = rdata; resp = rresp; ar = ar & !arr;
      @(posedge clock);
      arv <= ar;
    end
    rready <= 0;
  endtask : axi_rd
  task automatic dma_cycle(input logic w, input logic r, input logic [7:0] mask, input logic [7:0] exp);
    wd <= w; rdq <= r; go <= 1;
    @(posedge clock);
    go <= 0;
    repeat (24) @(posedge clock);
    check(seen | mask, exp);
  endtask : dma_cycle
  task automatic proc(input logic al, input logic a, input logic r, input logic w);
    pAle <= al; a0 <= a; pRd <= r; pWr <= w;
    repeat (5) @(posedge clock);
  endtask : proc
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    check({rsN, wsN, dsN, la0, waitReq, bv, rv}, 7'b1110000);
    @(posedge clock);
    nrst <= 1;
    axi_rd(CTRL_OFFSET);
    check(rd32, CTRL_RESET);
    check(resp, RESP_OKAY);
    axi_rd(STATUS_OFFSET);
    // sequencer bits free-run, so every bit except the sequencer bits is compared
    check(rd32 & 32'hFFFF_FFF8, 32'h1 << STAT_BYTE_BIT);
    check(resp, RESP_OKAY);
    axi_rd(4'hC);
    check(resp, RESP_SLVERR);
    $display("test registers done");
    // processor mode: odd byte written first, even byte read first
    sel <= 1;
    proc(1, 1, 0, 0);
    check(la0, 1'b1);
    proc(0, 0, 0, 1);
    check({la0, lClk, toDma, rsN}, 4'b1101);
    proc(1, 0, 0, 0);
    proc(0, 1, 0, 1);
    check({la0, lClk, toDma, dsN, dsO}, 5'b00101);
    proc(0, 1, 1, 0);
    check({toBus, lDrv, dsN}, 3'b100);
    proc(1, 1, 0, 0);
    proc(0, 0, 1, 0);
    check({la0, toBus, lDrv}, 3'b101);
    proc(0, 0, 0, 0);
    sel <= 0;
    $display("test processor done");
    own <= 1;
    repeat (3) @(posedge clock);
    dma_cycle(1, 1, 8'h00, 8'b1111_1001);
    dma_cycle(0, 1, 8'h10, 8'b1001_1001);
    dma_cycle(0, 0, 8'h00, 8'b1000_0111);
    check(la0, 1'b0);
    axi_wr(CTRL_OFFSET, 32'h0000_0000);
    check(resp, RESP_OKAY);
    dma_cycle(1, 1, 8'h00, 8'h00);
    axi_wr(CTRL_OFFSET, 32'h0000_0001);
    dma_cycle(1, 1, 8'h00, 8'b1111_1001);
    $display("test dma done");
    stop_test();
  end
endmodule : test_bwb_bridge
`default_nettype wire
